// ===== common/pprb_pkg.sv
// constants for the password protected register bank
// assumes an 8-bit register space with a 32-entry implemented window
package pprb_pkg;

	localparam int unsigned REG_COUNT = 32;

	// register offsets
	localparam logic [7:0] ADDR_CHIP_IDENTITY    = 8'h00;
	localparam logic [7:0] ADDR_POWER_PATH       = 8'h01;
	localparam logic [7:0] ADDR_INT_FLAGS_MASKS  = 8'h02;
	localparam logic [7:0] ADDR_CHARGER_0        = 8'h03;
	localparam logic [7:0] ADDR_CHARGER_1        = 8'h04;
	localparam logic [7:0] ADDR_CHARGER_2        = 8'h05;
	localparam logic [7:0] ADDR_CHARGER_3        = 8'h06;
	localparam logic [7:0] ADDR_BACKLIGHT_CTRL   = 8'h07;
	localparam logic [7:0] ADDR_BACKLIGHT_DUTY   = 8'h08;
	localparam logic [7:0] ADDR_ANALOG_MUX       = 8'h09;
	localparam logic [7:0] ADDR_DEVICE_STATUS    = 8'h0a;
	localparam logic [7:0] ADDR_UNLOCK_KEY       = 8'h0b;
	localparam logic [7:0] ADDR_POWER_GOOD_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_POWER_GOOD_DELAY = 8'h0d;
	localparam logic [7:0] ADDR_BUCK1_VOLTAGE    = 8'h0e;
	localparam logic [7:0] ADDR_BUCK2_VOLTAGE    = 8'h0f;
	localparam logic [7:0] ADDR_BUCK3_VOLTAGE    = 8'h10;
	localparam logic [7:0] ADDR_BUCK_SLEW        = 8'h11;
	localparam logic [7:0] ADDR_LINEAR1_VOLTAGE  = 8'h12;
	localparam logic [7:0] ADDR_LINEAR2_VOLTAGE  = 8'h13;
	localparam logic [7:0] ADDR_LOAD_SW1_VOLTAGE = 8'h14;
	localparam logic [7:0] ADDR_LOAD_SW2_VOLTAGE = 8'h15;
	localparam logic [7:0] ADDR_RAIL_ENABLE      = 8'h16;
	localparam logic [7:0] ADDR_UVLO_CONTROL     = 8'h18;
	localparam logic [7:0] ADDR_STROBE_1         = 8'h19;
	localparam logic [7:0] ADDR_STROBE_2         = 8'h1a;
	localparam logic [7:0] ADDR_STROBE_3         = 8'h1b;
	localparam logic [7:0] ADDR_STROBE_4         = 8'h1c;
	localparam logic [7:0] ADDR_DELAY_1          = 8'h1d;
	localparam logic [7:0] ADDR_DELAY_2          = 8'h1e;

	// unlock scheme
	localparam logic [7:0] UNLOCK_XOR_KEY = 8'h7d;
	localparam logic [7:0] UNLOCK_CLEARED = 8'h00;

	// one bit per offset: implemented, single unlock, double unlock
	localparam logic [31:0] MAPPED_MAP       = 32'h7f7f_ffff;
	localparam logic [31:0] SINGLE_LEVEL_MAP = 32'h7f40_2000;
	localparam logic [31:0] DOUBLE_LEVEL_MAP = 32'h003f_c000;

	// writable bits; read-only bits keep their reset value
	localparam logic [7:0] MASK_READ_ONLY  = 8'h00;
	localparam logic [7:0] MASK_INT_FLAGS  = 8'hf0;
	localparam logic [7:0] MASK_READ_WRITE = 8'hff;

	// fixed reset values
	localparam logic [7:0] RST_ZERO            = 8'h00;
	localparam logic [7:0] RST_POWER_PATH      = 8'h3d;
	localparam logic [7:0] RST_INT_FLAGS_MASKS = 8'h80;
	localparam logic [7:0] RST_CHARGER_1       = 8'hb1;
	localparam logic [7:0] RST_CHARGER_2       = 8'h80;
	localparam logic [7:0] RST_CHARGER_3       = 8'hb2;
	localparam logic [7:0] RST_BACKLIGHT_CTRL  = 8'hb1;
	localparam logic [7:0] RST_POWER_GOOD_DLY  = 8'h0c;
	localparam logic [7:0] RST_BUCK3_VOLTAGE   = 8'h08;
	localparam logic [7:0] RST_BUCK_SLEW       = 8'h06;
	localparam logic [7:0] RST_LINEAR1_VOLTAGE = 8'h09;
	localparam logic [7:0] RST_LINEAR2_VOLTAGE = 8'h38;
	localparam logic [7:0] RST_UVLO_CONTROL    = 8'h03;
	localparam logic [7:0] RST_STROBE_4        = 8'h40;

	// long push-button hold
	localparam longint unsigned CLK_HZ           = 100_000_000;
	localparam longint unsigned PB_HOLD_S        = 8;
	localparam int unsigned     PB_HOLD_CYCLES   = int'(PB_HOLD_S * CLK_HZ);

	typedef enum logic [2:0] {
		PHASE_IDLE    = 3'b001,
		PHASE_SUBADDR = 3'b010,
		PHASE_DATA    = 3'b100
	} pprb_phase_type;

	typedef enum logic [3:0] {
		PEND_NONE     = 4'b0001,
		PEND_FIRST    = 4'b0010,
		PEND_WAIT_KEY = 4'b0100,
		PEND_ARMED    = 4'b1000
	} pprb_pend_type;

endpackage

// ===== design/pprb_register_bank.sv
// register file with write-unlock scheme behind a byte-level serial target
// assumes a bit engine on mclk delivering start, byte, read request and stop pulses
`timescale 1ns/1ps

module pprb_register_bank #(
	parameter logic [7:0]  CHIP_IDENTITY_VALUE = 8'h5a, // arbitrary
	parameter logic [7:0]  BUCK1_DEFAULT       = 8'h00,
	parameter logic [7:0]  BUCK2_DEFAULT       = 8'h00,
	parameter logic [7:0]  LOAD_SW1_DEFAULT    = 8'h00,
	parameter logic [7:0]  LOAD_SW2_DEFAULT    = 8'h00,
	parameter logic [7:0]  STROBE_1_DEFAULT    = 8'h00,
	parameter logic [7:0]  STROBE_2_DEFAULT    = 8'h00,
	parameter logic [7:0]  STROBE_3_DEFAULT    = 8'h00,
	parameter logic [7:0]  DELAY_1_DEFAULT     = 8'h00,
	parameter int unsigned LONG_PRESS_CYCLES   = pprb_pkg::PB_HOLD_CYCLES
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         bus_start,
	input  wire logic         bus_read,
	input  wire logic         bus_wr_valid,
	input  wire logic [7:0]   bus_wr_data,
	input  wire logic         bus_rd_req,
	input  wire logic         bus_stop,
	input  wire logic         leave_active,
	input  wire logic         fault_event,
	input  wire logic         external_reset_low_pin,
	input  wire logic         pushbutton_input,
	output logic      [7:0]   bus_rd_data,
	output logic              bus_rd_valid,
	output logic      [255:0] reg_values
);

	// defaults per offset, variant ones from parameters
	function automatic logic [7:0] pick_default(input int unsigned a);
		logic [7:0] v;
		v = pprb_pkg::RST_ZERO;
		case (a)
			32'(pprb_pkg::ADDR_CHIP_IDENTITY):    v = CHIP_IDENTITY_VALUE;
			32'(pprb_pkg::ADDR_POWER_PATH):       v = pprb_pkg::RST_POWER_PATH;
			32'(pprb_pkg::ADDR_INT_FLAGS_MASKS):  v = pprb_pkg::RST_INT_FLAGS_MASKS;
			32'(pprb_pkg::ADDR_CHARGER_1):        v = pprb_pkg::RST_CHARGER_1;
			32'(pprb_pkg::ADDR_CHARGER_2):        v = pprb_pkg::RST_CHARGER_2;
			32'(pprb_pkg::ADDR_CHARGER_3):        v = pprb_pkg::RST_CHARGER_3;
			32'(pprb_pkg::ADDR_BACKLIGHT_CTRL):   v = pprb_pkg::RST_BACKLIGHT_CTRL;
			32'(pprb_pkg::ADDR_POWER_GOOD_DELAY): v = pprb_pkg::RST_POWER_GOOD_DLY;
			32'(pprb_pkg::ADDR_BUCK1_VOLTAGE):    v = BUCK1_DEFAULT;
			32'(pprb_pkg::ADDR_BUCK2_VOLTAGE):    v = BUCK2_DEFAULT;
			32'(pprb_pkg::ADDR_BUCK3_VOLTAGE):    v = pprb_pkg::RST_BUCK3_VOLTAGE;
			32'(pprb_pkg::ADDR_BUCK_SLEW):        v = pprb_pkg::RST_BUCK_SLEW;
			32'(pprb_pkg::ADDR_LINEAR1_VOLTAGE):  v = pprb_pkg::RST_LINEAR1_VOLTAGE;
			32'(pprb_pkg::ADDR_LINEAR2_VOLTAGE):  v = pprb_pkg::RST_LINEAR2_VOLTAGE;
			32'(pprb_pkg::ADDR_LOAD_SW1_VOLTAGE): v = LOAD_SW1_DEFAULT;
			32'(pprb_pkg::ADDR_LOAD_SW2_VOLTAGE): v = LOAD_SW2_DEFAULT;
			32'(pprb_pkg::ADDR_UVLO_CONTROL):     v = pprb_pkg::RST_UVLO_CONTROL;
			32'(pprb_pkg::ADDR_STROBE_1):         v = STROBE_1_DEFAULT;
			32'(pprb_pkg::ADDR_STROBE_2):         v = STROBE_2_DEFAULT;
			32'(pprb_pkg::ADDR_STROBE_3):         v = STROBE_3_DEFAULT;
			32'(pprb_pkg::ADDR_STROBE_4):         v = pprb_pkg::RST_STROBE_4;
			32'(pprb_pkg::ADDR_DELAY_1):          v = DELAY_1_DEFAULT;
			default:                              v = pprb_pkg::RST_ZERO;
		endcase
		return v;
	endfunction

	function automatic logic [7:0] pick_mask(input int unsigned a);
		logic [7:0] m;
		m = pprb_pkg::MASK_READ_WRITE;
		if (a == 32'(pprb_pkg::ADDR_CHIP_IDENTITY)) begin
			m = pprb_pkg::MASK_READ_ONLY;
		end else if (a == 32'(pprb_pkg::ADDR_POWER_GOOD_FLAGS)) begin
			m = pprb_pkg::MASK_READ_ONLY;
		end else if (a == 32'(pprb_pkg::ADDR_INT_FLAGS_MASKS)) begin
			m = pprb_pkg::MASK_INT_FLAGS;
		end else if (pprb_pkg::MAPPED_MAP[a] == 1'b0) begin
			m = pprb_pkg::MASK_READ_ONLY;
		end
		return m;
	endfunction

	// pin synchronisers: three stages, level moves when the last two agree
	logic [1:0] pin_raw;
	logic [1:0] pin_s1_reg;
	logic [1:0] pin_s2_reg;
	logic [1:0] pin_s3_reg;
	logic [1:0] pin_level_reg;

	assign pin_raw = {pushbutton_input, external_reset_low_pin};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_pin_sync
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					pin_s1_reg[g]    <= 1'b1;
					pin_s2_reg[g]    <= 1'b1;
					pin_s3_reg[g]    <= 1'b1;
					pin_level_reg[g] <= 1'b1;
				end else begin
					pin_s1_reg[g] <= pin_raw[g];
					pin_s2_reg[g] <= pin_s1_reg[g];
					pin_s3_reg[g] <= pin_s2_reg[g];
					if (pin_s2_reg[g] == pin_s3_reg[g]) begin
						pin_level_reg[g] <= pin_s3_reg[g];
					end
				end
			end
		end
	endgenerate

	// long press: fires every full hold period while the button stays low
	logic [31:0] pb_cnt_reg;
	logic        pb_fire_reg;
	wire  logic  pb_low;
	wire  logic  pb_done;

	assign pb_low  = ~pin_level_reg[1];
	assign pb_done = (pb_cnt_reg == 32'(LONG_PRESS_CYCLES - 1));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pb_cnt_reg  <= 32'h0000_0000;
			pb_fire_reg <= 1'b0;
		end else if (!pb_low) begin
			pb_cnt_reg  <= 32'h0000_0000;
			pb_fire_reg <= 1'b0;
		end else if (pb_done) begin
			pb_cnt_reg  <= 32'h0000_0000;
			pb_fire_reg <= 1'b1;
		end else begin
			pb_cnt_reg  <= pb_cnt_reg + 32'h0000_0001;
			pb_fire_reg <= 1'b0;
		end
	end

	// held for as long as the reset pin stays low
	wire logic soft_rst;
	assign soft_rst = leave_active | fault_event | ~pin_level_reg[0] | pb_fire_reg;

	// transaction tracking
	pprb_pkg::pprb_phase_type phase_reg;
	pprb_pkg::pprb_pend_type  pend_reg;
	logic [7:0]               ptr_reg;
	logic                     txn_wrote_key_reg;
	logic                     txn_other_reg;
	logic [7:0]               pend_addr_reg;
	logic [7:0]               pend_data_reg;
	logic [7:0]               regs_reg [pprb_pkg::REG_COUNT];

	wire logic [4:0] idx;
	wire logic       in_map;
	wire logic       sub_byte;
	wire logic       data_byte;
	wire logic       is_key;
	wire logic       key_match;
	wire logic       single_prot;
	wire logic       double_prot;
	wire logic       open_reg;
	wire logic       dbl_ok;
	wire logic       dbl_second;
	wire logic       commit;
	wire logic       key_clear;
	wire logic       key_only;
	wire logic [7:0] merged;
	wire logic [7:0] wmask;

	assign idx       = ptr_reg[4:0];
	assign in_map    = (ptr_reg[7:5] == 3'h0) && pprb_pkg::MAPPED_MAP[idx];
	assign sub_byte  = bus_wr_valid && (phase_reg == pprb_pkg::PHASE_SUBADDR);
	assign data_byte = bus_wr_valid && (phase_reg == pprb_pkg::PHASE_DATA);
	assign is_key    = (ptr_reg == pprb_pkg::ADDR_UNLOCK_KEY);
	// checked at this byte's own address, also inside a burst
	assign key_match = ((regs_reg[pprb_pkg::ADDR_UNLOCK_KEY[4:0]] ^ ptr_reg)
		== pprb_pkg::UNLOCK_XOR_KEY);
	assign single_prot = in_map && pprb_pkg::SINGLE_LEVEL_MAP[idx];
	assign double_prot = in_map && pprb_pkg::DOUBLE_LEVEL_MAP[idx];
	// key register lies below the protected range and so stays open
	assign open_reg    = in_map && !single_prot && !double_prot;
	assign dbl_ok      = data_byte && double_prot && key_match;
	assign dbl_second  = dbl_ok && (pend_reg == pprb_pkg::PEND_ARMED)
		&& (pend_addr_reg == ptr_reg) && (pend_data_reg == bus_wr_data);
	assign commit      = data_byte && (open_reg || (single_prot && key_match) || dbl_second);
	assign key_only    = txn_wrote_key_reg && !txn_other_reg;
	// a transaction that loaded the key leaves it in place
	assign key_clear   = bus_stop && !txn_wrote_key_reg;
	assign wmask       = pick_mask(32'(idx));
	assign merged      = (regs_reg[idx] & ~wmask) | (bus_wr_data & wmask);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= pprb_pkg::PHASE_IDLE;
			ptr_reg   <= 8'h00;
		end else if (bus_stop) begin
			phase_reg <= pprb_pkg::PHASE_IDLE;
		end else if (bus_start) begin
			phase_reg <= bus_read ? pprb_pkg::PHASE_DATA : pprb_pkg::PHASE_SUBADDR;
		end else if (sub_byte) begin
			ptr_reg   <= bus_wr_data;
			phase_reg <= pprb_pkg::PHASE_DATA;
		end else if (data_byte || (bus_rd_req && phase_reg == pprb_pkg::PHASE_DATA)) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// what kind of transaction this was, judged at its stop
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			txn_wrote_key_reg <= 1'b0;
			txn_other_reg     <= 1'b0;
		end else if (bus_stop || soft_rst) begin
			txn_wrote_key_reg <= 1'b0;
			txn_other_reg     <= 1'b0;
		end else if (data_byte && is_key) begin
			txn_wrote_key_reg <= 1'b1;
		end else if (data_byte || bus_rd_req) begin
			txn_other_reg <= 1'b1;
		end
	end

	// double level pending store: survives exactly one key-only transaction
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend_reg      <= pprb_pkg::PEND_NONE;
			pend_addr_reg <= 8'h00;
			pend_data_reg <= 8'h00;
		end else if (soft_rst) begin
			pend_reg <= pprb_pkg::PEND_NONE;
		end else if (bus_stop) begin
			case (pend_reg)
				pprb_pkg::PEND_FIRST: begin
					pend_reg <= pprb_pkg::PEND_WAIT_KEY;
				end
				pprb_pkg::PEND_WAIT_KEY: begin
					pend_reg <= key_only ? pprb_pkg::PEND_ARMED : pprb_pkg::PEND_NONE;
				end
				default: begin
					pend_reg <= pprb_pkg::PEND_NONE;
				end
			endcase
		end else if (dbl_second) begin
			pend_reg <= pprb_pkg::PEND_NONE;
		end else if (dbl_ok) begin
			pend_reg      <= pprb_pkg::PEND_FIRST;
			pend_addr_reg <= ptr_reg;
			pend_data_reg <= bus_wr_data;
		end else if (data_byte && pend_reg == pprb_pkg::PEND_ARMED) begin
			// a different byte in the confirming transaction voids the pair
			pend_reg <= pprb_pkg::PEND_NONE;
		end
	end

	// storage, one entry per offset
	generate
		for (g = 0; g < pprb_pkg::REG_COUNT; g++) begin : gen_regs
			localparam logic [7:0] DEF = pick_default(g);
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					regs_reg[g] <= DEF;
				end else if (soft_rst) begin
					regs_reg[g] <= DEF;
				end else if (g == 32'(pprb_pkg::ADDR_UNLOCK_KEY) && key_clear) begin
					regs_reg[g] <= pprb_pkg::UNLOCK_CLEARED;
				end else if (commit && ptr_reg == 8'(g)) begin
					regs_reg[g] <= merged;
				end
			end
			assign reg_values[g*8 +: 8] = regs_reg[g];
		end
	endgenerate

	// read path: unmapped offsets read as zero; no unlock is consulted
	wire logic [7:0] rd_mux;
	assign rd_mux = in_map ? regs_reg[idx] : 8'h00;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bus_rd_data  <= 8'h00;
			bus_rd_valid <= 1'b0;
		end else begin
			bus_rd_valid <= bus_rd_req && (phase_reg == pprb_pkg::PHASE_DATA);
			if (bus_rd_req && phase_reg == pprb_pkg::PHASE_DATA) begin
				bus_rd_data <= rd_mux;
			end
		end
	end

endmodule

// ===== bench/pprb_bank_sva.sv
// assertion checker for the register bank, watching its ports only
// assumes one clock and the byte-level strobe contract of the bank
`timescale 1ns/1ps
module pprb_bank_sva #(
	parameter int unsigned LONG_PRESS_CYCLES = 20
) (
	input wire logic         mclk,
	input wire logic         rstn,
	input wire logic         bus_start,
	input wire logic         bus_read,
	input wire logic         bus_wr_valid,
	input wire logic [7:0]   bus_wr_data,
	input wire logic         bus_rd_req,
	input wire logic         bus_stop,
	input wire logic         leave_active,
	input wire logic         fault_event,
	input wire logic         external_reset_low_pin,
	input wire logic         pushbutton_input,
	input wire logic [7:0]   bus_rd_data,
	input wire logic         bus_rd_valid,
	input wire logic [255:0] reg_values
);
	logic [7:0] ptr_reg;
	logic [4:0] idx_reg;
	logic [5:0] soft_reg;
	logic       act_reg;
	logic       rd_reg;
	logic       sub_reg;
	logic       key_reg;
	wire        soft_now = leave_active | fault_event;
	wire        pin_low  = ~external_reset_low_pin | ~pushbutton_input;
	// synced pin lags a few edges, so hold off checks for a while after any soft reset
	wire        quiet    = !soft_now && !pin_low && soft_reg == 6'h00;
	wire        data_wr  = bus_wr_valid && act_reg && !rd_reg && !sub_reg && !bus_stop && !bus_start;
	wire        rd_hit   = bus_rd_req && act_reg && rd_reg && !bus_stop && !bus_start;
	wire [7:0]  key      = reg_values[95:88];
	wire [7:0]  cur      = reg_values[{ptr_reg[4:0], 3'b000} +: 8];
	wire [7:0]  prev     = reg_values[{idx_reg, 3'b000} +: 8];
	wire        lvl1     = ptr_reg == 8'h0d || ptr_reg == 8'h16 || (ptr_reg >= 8'h18 && ptr_reg <= 8'h1e);
	wire        lvl2     = ptr_reg >= 8'h0e && ptr_reg <= 8'h15;
	wire        plain    = ptr_reg >= 8'h01 && ptr_reg <= 8'h0b && ptr_reg != 8'h02;
	wire        unlocked = (key ^ ptr_reg) == pprb_pkg::UNLOCK_XOR_KEY;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ptr_reg <= 8'h00;
			act_reg <= 1'b0;
			rd_reg  <= 1'b0;
			sub_reg <= 1'b0;
			key_reg <= 1'b0;
		end else if (bus_stop) begin
			act_reg <= 1'b0;
			key_reg <= 1'b0;
		end else if (bus_start) begin
			act_reg <= 1'b1;
			rd_reg  <= bus_read;
			sub_reg <= !bus_read;
		end else if (bus_wr_valid && act_reg && !rd_reg) begin
			ptr_reg <= sub_reg ? bus_wr_data : ptr_reg + 8'h01;
			sub_reg <= 1'b0;
			key_reg <= key_reg | (!sub_reg && ptr_reg == 8'h0b);
		end else if (rd_hit) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		idx_reg  <= ptr_reg[4:0];
		soft_reg <= {soft_reg[4:0], soft_now | pin_low};
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_read_answer: assert property (rd_hit && ptr_reg <= 8'h1e && ptr_reg != 8'h17 |=>
		bus_rd_valid && bus_rd_data == $past(cur)) else $error("read byte wrong or late");
	a_read_cause: assert property (bus_rd_valid |-> $past(rd_hit))
		else $error("read byte without a request");
	a_key_clear: assert property (bus_stop && act_reg && !key_reg |=> key == 8'h00)
		else $error("unlock key not cleared after transaction");
	a_key_load: assert property (data_wr && ptr_reg == 8'h0b && quiet |=>
		key == $past(bus_wr_data)) else $error("unlock key write refused");
	a_key_kept: assert property (bus_stop && key_reg && quiet |=> $stable(key))
		else $error("unlock key cleared by its own write");
	a_id_fixed: assert property ($stable(reg_values[7:0]) && reg_values[103:96] == 8'h00)
		else $error("read-only register changed");
	a_flags_ro: assert property (reg_values[19:16] == 4'h0)
		else $error("read-only flag bits changed");
	a_locked_drop: assert property (data_wr && (lvl1 || lvl2) && !unlocked && quiet |=>
		prev == $past(cur)) else $error("locked write changed a register");
	a_single_commit: assert property (data_wr && lvl1 && unlocked && quiet |=>
		prev == $past(bus_wr_data)) else $error("unlocked single write lost");
	a_plain_write: assert property (data_wr && plain && quiet |=>
		prev == $past(bus_wr_data)) else $error("open register write lost");

	a_soft_reload: assert property (leave_active || fault_event |=>
		reg_values[15:8] == 8'h3d && reg_values[183:176] == 8'h00)
		else $error("soft reset did not reload defaults");

	c_single: cover property (data_wr && lvl1 && unlocked);
	c_double: cover property (data_wr && lvl2 && unlocked);
	c_read: cover property (rd_hit);
endmodule

bind pprb_register_bank pprb_bank_sva #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)) u_sva (
	.mclk(mclk), .rstn(rstn), .bus_start(bus_start), .bus_read(bus_read),
	.bus_wr_valid(bus_wr_valid), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
	.bus_stop(bus_stop), .leave_active(leave_active), .fault_event(fault_event),
	.external_reset_low_pin(external_reset_low_pin), .pushbutton_input(pushbutton_input),
	.bus_rd_data(bus_rd_data), .bus_rd_valid(bus_rd_valid), .reg_values(reg_values)
);

// ===== bench/pprb_host_model.sv
// host controller model issuing byte-level transactions to the bank
// assumes the bench calls one task at a time on the shared clock
`timescale 1ns/1ps
module pprb_host_model (
	input  wire logic       mclk,
	output logic            bus_start,
	output logic            bus_read,
	output logic            bus_wr_valid,
	output logic [7:0]      bus_wr_data,
	output logic            bus_rd_req,
	output logic            bus_stop,
	input  wire logic [7:0] bus_rd_data,
	input  wire logic       bus_rd_valid
);
	initial begin
		bus_start    = 1'b0;
		bus_read     = 1'b0;
		bus_wr_valid = 1'b0;
		bus_wr_data  = 8'h00;
		bus_rd_req   = 1'b0;
		bus_stop     = 1'b0;
	end

	// released data byte flips every cycle so a stale value is never mistaken for data
	task automatic step(input logic s, r, v, input logic [7:0] d, input logic q, p);
		@(posedge mclk);
		bus_start    <= s;
		bus_read     <= r;
		bus_wr_valid <= v;
		bus_wr_data  <= v ? d : ~bus_wr_data;
		bus_rd_req   <= q;
		bus_stop     <= p;
	endtask

	task automatic write(input logic [7:0] a, d0, input logic two, input logic [7:0] d1);
		step(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b1, a, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b1, d0, 1'b0, 1'b0);
		if (two) step(1'b0, 1'b0, 1'b1, d1, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		step(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
	endtask

	// one unlock per protected write, nothing else between a double pair
	task automatic unlock(input logic [7:0] a);
		write(pprb_pkg::ADDR_UNLOCK_KEY, a ^ 8'h7d, 1'b0, 8'h00);
	endtask

	// subaddress, repeated start, one byte read; answer taken with the stop edge
	task automatic read(input logic [7:0] a, output logic [7:0] q);
		step(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b1, a, 1'b0, 1'b0);
		step(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		step(1'b0, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0);
		step(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		step(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
		q = bus_rd_valid ? bus_rd_data : 8'hxx;
		step(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
	endtask
endmodule

// ===== bench/pprb_register_bank_bench.sv
// self-checking bench: host model drives the bank, register image is compared
// assumes a short long-press count so the push-button reload fits the run
`timescale 1ns/1ps
module pprb_register_bank_bench;
	localparam int unsigned LP     = 20;
	localparam logic [7:0]  ID_VAL = 8'h3c; // arbitrary
	localparam logic [7:0]  BUCK1  = 8'h2c;
	localparam logic [7:0]  DFLT [32] = '{
		ID_VAL, 8'h3d, 8'h80, 8'h00, 8'hb1, 8'h80, 8'hb2, 8'hb1,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, BUCK1, 8'h00,
		8'h08, 8'h06, 8'h09, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h03, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
	logic         mclk, rstn, leave_active, fault_event, external_reset_low_pin, pushbutton_input;
	logic         bus_start, bus_read, bus_wr_valid, bus_rd_req, bus_stop, bus_rd_valid;
	logic [7:0]   bus_wr_data, bus_rd_data, q, a;
	logic [3:0]   soft_sel;
	logic [255:0] reg_values;
	int           i, err_total, n_tests, cycles;

	pprb_register_bank #(.CHIP_IDENTITY_VALUE(ID_VAL), .BUCK1_DEFAULT(BUCK1),
		.LONG_PRESS_CYCLES(LP)) dut (
		.mclk(mclk), .rstn(rstn), .bus_start(bus_start), .bus_read(bus_read),
		.bus_wr_valid(bus_wr_valid), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
		.bus_stop(bus_stop), .leave_active(leave_active), .fault_event(fault_event),
		.external_reset_low_pin(external_reset_low_pin), .pushbutton_input(pushbutton_input),
		.bus_rd_data(bus_rd_data), .bus_rd_valid(bus_rd_valid), .reg_values(reg_values));
	pprb_host_model host (.mclk(mclk), .bus_start(bus_start), .bus_read(bus_read),
		.bus_wr_valid(bus_wr_valid), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
		.bus_stop(bus_stop), .bus_rd_data(bus_rd_data), .bus_rd_valid(bus_rd_valid));

	always #5 mclk = ~mclk;

	task automatic check(input string what, input logic [7:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// sampled on the falling edge so the key clear after stop has landed
	task automatic chkreg(input logic [7:0] ra, input logic [7:0] exp);
		@(negedge mclk);
		check($sformatf("reg %h", ra), exp, reg_values[{ra[4:0], 3'b000} +: 8]);
	endtask

	// bit 0 leave active, bit 1 fault, bit 2 reset pin low, bit 3 button low
	task automatic drive_soft(input logic [3:0] s);
		leave_active           <= s[0];
		fault_event            <= s[1];
		external_reset_low_pin <= !s[2];
		pushbutton_input       <= !s[3];
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		soft_sel = 4'h0;
		drive_soft(soft_sel);
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		for (i = 0; i < 32; i++) chkreg(8'(i), DFLT[i]);
		host.read(8'h00, q);
		check("id read", ID_VAL, q);
		host.write(8'h00, 8'hff, 1'b1, 8'h5a);
		chkreg(8'h00, ID_VAL);
		chkreg(8'h01, 8'h5a);
		host.write(8'h02, 8'hff, 1'b0, 8'h00);
		chkreg(8'h02, 8'hf0);
		host.write(8'h0c, 8'h55, 1'b0, 8'h00);
		chkreg(8'h0c, 8'h00);
		host.write(8'h0d, 8'h33, 1'b0, 8'h00);
		chkreg(8'h0d, 8'h0c);
		host.unlock(8'h16);
		chkreg(8'h0b, 8'h16 ^ 8'h7d);
		host.write(8'h0d, 8'h33, 1'b0, 8'h00);
		chkreg(8'h0d, 8'h0c);
		chkreg(8'h0b, 8'h00);
		host.unlock(8'h0d);
		host.read(8'h0d, q);
		check("locked read", 8'h0c, q);
		chkreg(8'h0b, 8'h00);
		host.unlock(8'h0d);
		host.write(8'h0c, 8'h11, 1'b1, 8'h22);
		chkreg(8'h0d, 8'h22);
		for (i = 8'h0d; i <= 8'h1e; i++) begin
			a = 8'(i);
			if (a != 8'h17) begin
				host.unlock(a);
				host.write(a, a ^ 8'hc3, 1'b0, 8'h00);
				chkreg(a, (a >= 8'h0e && a <= 8'h15) ? DFLT[i] : a ^ 8'hc3);
				host.unlock(a);
				host.write(a, a ^ 8'hc3, 1'b0, 8'h00);
				chkreg(a, a ^ 8'hc3);
			end
		end
		// mismatched pair, then a pair split by a read
		host.unlock(8'h10);
		host.write(8'h10, 8'h66, 1'b0, 8'h00);
		host.unlock(8'h10);
		host.write(8'h10, 8'h67, 1'b0, 8'h00);
		chkreg(8'h10, 8'h10 ^ 8'hc3);
		host.unlock(8'h10);
		host.write(8'h10, 8'h77, 1'b0, 8'h00);
		host.read(8'h01, q);
		host.unlock(8'h10);
		host.write(8'h10, 8'h77, 1'b0, 8'h00);
		chkreg(8'h10, 8'h10 ^ 8'hc3);
		for (i = 0; i < 4; i++) begin
			host.write(8'h01, 8'h00, 1'b0, 8'h00);
			host.unlock(8'h16);
			host.write(8'h16, 8'h5a, 1'b0, 8'h00);
			soft_sel = 4'h1 << i;
			@(posedge mclk);
			drive_soft(soft_sel);
			repeat (LP + 8) @(posedge mclk);
			soft_sel = 4'h0;
			drive_soft(soft_sel);
			repeat (6) @(posedge mclk);
			chkreg(8'h01, 8'h3d);
			chkreg(8'h16, 8'h00);
		end
		// power-on reset in mid-run also reloads defaults
		host.write(8'h01, 8'h00, 1'b0, 8'h00);
		chkreg(8'h01, 8'h00);
		@(posedge mclk);
		rstn <= 1'b0;
		@(posedge mclk);
		rstn <= 1'b1;
		chkreg(8'h01, 8'h3d);
		print_verdict();
	end
endmodule
